// ### rtl/eep_pkg.sv
// constants and types for the two-wire memory slave
package eep_pkg;

    // ****************************************
    // clock and times
    // ****************************************
    localparam int CLK_PERIOD_NS          = 4;
    localparam int GLITCH_NS              = 100;
    localparam int GLITCH_CYCLES          = GLITCH_NS / CLK_PERIOD_NS;
    localparam int POWERUP_READY_DELAY_MS = 1;
    localparam int PU_CYCLES              = POWERUP_READY_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLE_TIME_MS  = 5;
    localparam int PROG_CYCLES            = PROGRAM_CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FAST_PLUS_KHZ          = 1000;

    // ****************************************
    // sizes and bit counts
    // ****************************************
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 8;
    localparam int MEM_DEPTH  = 4096;
    localparam int PAGE_W     = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int TIMER_W    = 21;
    localparam int GLITCH_W   = 5;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV  = 3'h1,
        ST_AHI  = 3'h2,
        ST_ALO  = 3'h3,
        ST_WR   = 3'h4,
        ST_RD   = 3'h5,
        ST_SKIP = 3'h6
    } eep_state_t;

    typedef struct packed {
        logic       pwr;
        logic       wp;
        logic [2:0] cs;
        logic       sda;
        logic       scl;
    } eep_pins_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  data;
    } eep_word_t;

    localparam eep_pins_t PINS_RST = 7'h03;

endpackage

// ### rtl/eep_slave.sv
// two-wire memory slave: pin sync, glitch filter, protocol, write buffer, array
`timescale 1ns/10ps
`default_nettype none

module eep_fifo #(
    parameter int W = 20,
    parameter int D = 16
) (
    // system
    input  wire logic         clk,
    input  wire logic         clr,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_ff [0:D-1];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_ff != (AW+1)'(D));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rp_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= wp_ff + AW'(push);
            rp_ff <= rp_ff + AW'(pop);
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module eep_slave #(
    parameter int         PU_CYCLES   = eep_pkg::PU_CYCLES,
    parameter int         PROG_CYCLES = eep_pkg::PROG_CYCLES,
    // device-type code, value arbitrary
    parameter logic [3:0] DEV_TYPE    = 4'h6
) (
    // system
    input  wire logic clk,
    input  wire logic sys_rst,
    // supply monitor level
    input  wire logic supply_ok,
    // two-wire bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o_ff,
    output logic      sda_oe_ff,
    // straps
    input  wire logic chip_select_bit0,
    input  wire logic chip_select_bit1,
    input  wire logic chip_select_bit2,
    input  wire logic write_protect,
    // status
    output logic      ready_ff,
    output logic      prog_busy_ff
);
    // ****************************************
    // pin synchronisers and glitch filter
    // ****************************************
    eep_pkg::eep_pins_t s1_ff;
    eep_pkg::eep_pins_t s2_ff;
    logic [1:0]         flt_ff;
    logic [1:0]         fq_ff;
    logic [1:0][4:0]    fcnt_ff;
    logic [1:0]         raw;
    logic               pwr_ok;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_ff <= eep_pkg::PINS_RST;
            s2_ff <= eep_pkg::PINS_RST;
        end else begin
            s1_ff <= {supply_ok, write_protect, chip_select_bit2,
                      chip_select_bit1, chip_select_bit0, sda_i, scl_i};
            s2_ff <= s1_ff;
        end
    end

    assign raw    = {s2_ff.sda, s2_ff.scl};
    assign pwr_ok = s2_ff.pwr;

    // level accepted only after it held past the glitch window
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flt_ff  <= 2'h3;
            fq_ff   <= 2'h3;
            fcnt_ff <= '0;
        end else begin
            fq_ff <= flt_ff;
            for (int i = 0; i < 2; i++) begin
                if (raw[i] == flt_ff[i]) begin
                    fcnt_ff[i] <= '0;
                end else if (fcnt_ff[i] == eep_pkg::GLITCH_W'(eep_pkg::GLITCH_CYCLES)) begin
                    flt_ff[i]  <= raw[i];
                    fcnt_ff[i] <= '0;
                end else begin
                    fcnt_ff[i] <= fcnt_ff[i] + 5'h01;
                end
            end
        end
    end

    // clock is only received; master owns it, rates to fast-plus
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = flt_ff[0] && !fq_ff[0];
    assign scl_fall = !flt_ff[0] && fq_ff[0];
    assign start_ev = flt_ff[0] && fq_ff[0] && fq_ff[1] && !flt_ff[1];
    assign stop_ev  = flt_ff[0] && fq_ff[0] && !fq_ff[1] && flt_ff[1];

    // ****************************************
    // power-on reset and ready delay
    // ****************************************
    logic [20:0] pu_cnt_ff;

    always_ff @(posedge clk) begin
        if (sys_rst || !pwr_ok) begin
            pu_cnt_ff <= '0;
            ready_ff  <= 1'b0;
        end else if (!ready_ff) begin
            ready_ff  <= (pu_cnt_ff == 21'(PU_CYCLES - 1));
            pu_cnt_ff <= pu_cnt_ff + 21'(pu_cnt_ff != 21'(PU_CYCLES - 1));
        end
    end

    // ****************************************
    // protocol engine
    // ****************************************
    eep_pkg::eep_state_t st_ff;
    logic [3:0]          cnt_ff;
    logic [7:0]          sh_ff;
    logic [7:0]          tx_ff;
    logic [11:0]         addr_ff;
    logic                rw_ff;
    logic                wp_lat_ff;
    logic                match;
    logic                ack_ok;
    logic                fifo_push;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_clr;
    logic [7:0]          mem_ff [0:eep_pkg::MEM_DEPTH-1];
    eep_pkg::eep_word_t  in_word;
    eep_pkg::eep_word_t  out_word;

    assign match = (sh_ff[7:4] == DEV_TYPE) && (sh_ff[3:1] == s2_ff.cs)
                   && !prog_busy_ff && ready_ff;

    always_comb begin
        case (st_ff)
            eep_pkg::ST_DEV: ack_ok = match;
            eep_pkg::ST_AHI: ack_ok = 1'b1;
            eep_pkg::ST_ALO: ack_ok = 1'b1;
            eep_pkg::ST_WR:  ack_ok = !wp_lat_ff && fifo_in_ready;
            default:         ack_ok = 1'b0;
        endcase
    end

    assign fifo_push = scl_fall && st_ff == eep_pkg::ST_WR && cnt_ff == eep_pkg::BIT_ACK
                       && ack_ok;
    assign in_word   = {addr_ff, sh_ff};

    always_ff @(posedge clk) begin
        sda_o_ff <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !pwr_ok) begin
            st_ff     <= eep_pkg::ST_IDLE;
            cnt_ff    <= '0;
            sh_ff     <= '0;
            tx_ff     <= '0;
            addr_ff   <= '0;
            rw_ff     <= 1'b0;
            wp_lat_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (start_ev || stop_ev) begin
            st_ff     <= (start_ev && ready_ff) ? eep_pkg::ST_DEV : eep_pkg::ST_IDLE;
            cnt_ff    <= '0;
            sda_oe_ff <= 1'b0;
        end else if (scl_rise && st_ff != eep_pkg::ST_IDLE) begin
            if (cnt_ff != eep_pkg::BIT_END) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
            if (cnt_ff < eep_pkg::BIT_ACK) begin
                sh_ff <= {sh_ff[6:0], flt_ff[1]};
            end
            if (st_ff == eep_pkg::ST_RD && cnt_ff == eep_pkg::BIT_ACK && flt_ff[1]) begin
                st_ff <= eep_pkg::ST_SKIP;
            end
        end else if (scl_fall && st_ff != eep_pkg::ST_IDLE) begin
            if (cnt_ff == eep_pkg::BIT_ACK) begin
                sda_oe_ff <= ack_ok;
                if (!ack_ok && st_ff != eep_pkg::ST_RD) begin
                    st_ff <= eep_pkg::ST_SKIP;
                end
                case (st_ff)
                    eep_pkg::ST_DEV: rw_ff <= sh_ff[0];
                    eep_pkg::ST_AHI: addr_ff[11:8] <= sh_ff[3:0];
                    eep_pkg::ST_ALO: addr_ff[7:0] <= sh_ff;
                    eep_pkg::ST_WR:  addr_ff[4:0] <= addr_ff[4:0] + 5'(ack_ok);
                    default: ;
                endcase
            end else if (cnt_ff == eep_pkg::BIT_END) begin
                cnt_ff    <= '0;
                sda_oe_ff <= 1'b0;
                case (st_ff)
                    eep_pkg::ST_DEV: st_ff <= rw_ff ? eep_pkg::ST_RD : eep_pkg::ST_AHI;
                    eep_pkg::ST_AHI: st_ff <= eep_pkg::ST_ALO;
                    eep_pkg::ST_ALO: begin
                        st_ff     <= eep_pkg::ST_WR;
                        wp_lat_ff <= s2_ff.wp;
                    end
                    default: ;
                endcase
                if (st_ff == eep_pkg::ST_RD || (st_ff == eep_pkg::ST_DEV && rw_ff)) begin
                    tx_ff     <= {mem_ff[addr_ff][6:0], 1'b1};
                    sda_oe_ff <= !mem_ff[addr_ff][7];
                    addr_ff   <= addr_ff + 12'h001;
                end
            end else if (st_ff == eep_pkg::ST_RD) begin
                sda_oe_ff <= !tx_ff[7];
                tx_ff     <= {tx_ff[6:0], 1'b1};
            end
        end
    end

    // ****************************************
    // write buffer, programming cycle, array
    // ****************************************
    logic [20:0] prog_cnt_ff;

    // a fresh start drops a page that never saw its stop
    assign fifo_clr = sys_rst || !pwr_ok || (start_ev && !prog_busy_ff);

    eep_fifo #(
        .W (eep_pkg::ADDR_W + eep_pkg::DATA_W),
        .D (eep_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .clr       (fifo_clr),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (in_word),
        .out_valid (fifo_out_valid),
        .out_ready (prog_busy_ff),
        .out_data  (out_word)
    );

    always_ff @(posedge clk) begin
        if (sys_rst || !pwr_ok) begin
            prog_busy_ff <= 1'b0;
            prog_cnt_ff  <= '0;
        end else if (!prog_busy_ff) begin
            prog_cnt_ff  <= '0;
            // buffered bytes are programmed even after a refused byte ended the session
            prog_busy_ff <= stop_ev && fifo_out_valid;
        end else if (prog_cnt_ff == 21'(PROG_CYCLES - 1)) begin
            prog_busy_ff <= 1'b0;
        end else begin
            prog_cnt_ff <= prog_cnt_ff + 21'h000001;
        end
    end

    always_ff @(posedge clk) begin
        if (fifo_out_valid && prog_busy_ff) begin
            mem_ff[out_word.addr] <= out_word.data;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst || !pwr_ok);

    sequence dev_slot_s;
        scl_fall && st_ff == eep_pkg::ST_DEV && cnt_ff == eep_pkg::BIT_ACK
        && !start_ev && !stop_ev;
    endsequence

    sequence wr_slot_s;
        scl_fall && st_ff == eep_pkg::ST_WR && cnt_ff == eep_pkg::BIT_ACK;
    endsequence

    glitch_hold_a: assert property ($changed(flt_ff[0]) |->
        $past(fcnt_ff[0]) == eep_pkg::GLITCH_W'(eep_pkg::GLITCH_CYCLES))
        else $error("clock filter passed a short pulse");
    ready_delay_a: assert property ($rose(ready_ff) |->
        $past(pu_cnt_ff) == 21'(PU_CYCLES - 1))
        else $error("ready came at the wrong time");
    brownout_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        !pwr_ok |=> !ready_ff && st_ff == eep_pkg::ST_IDLE && !sda_oe_ff)
        else $error("supply loss did not reset");
    open_drain_a: assert property (sda_oe_ff |->
        !sda_o_ff && st_ff != eep_pkg::ST_IDLE)
        else $error("data line driven outside a transfer");
    rise_sample_a: assert property (scl_rise && cnt_ff < eep_pkg::BIT_ACK
        && st_ff != eep_pkg::ST_IDLE |=> sh_ff[0] == $past(flt_ff[1]))
        else $error("bit not sampled on rising clock");
    high_stable_a: assert property (flt_ff[0] && $past(flt_ff[0])
        && !$past(start_ev || stop_ev) |-> $stable(sda_oe_ff))
        else $error("data changed while clock high");
    addr_match_a: assert property (dev_slot_s ##0 (sh_ff[3:1] != s2_ff.cs
        || sh_ff[7:4] != DEV_TYPE) |=> !sda_oe_ff ##1 st_ff == eep_pkg::ST_SKIP)
        else $error("acked a foreign address");
    wp_refuse_a: assert property (wr_slot_s ##0 wp_lat_ff |-> !fifo_push
        ##1 (!sda_oe_ff && st_ff == eep_pkg::ST_SKIP))
        else $error("protected write accepted");
    prog_quiet_a: assert property (prog_busy_ff |-> !sda_oe_ff
        && prog_cnt_ff <= 21'(PROG_CYCLES - 1))
        else $error("device active during programming");
    prog_end_a: assert property (prog_busy_ff && prog_cnt_ff == 21'(PROG_CYCLES - 1)
        |=> !prog_busy_ff && !fifo_out_valid)
        else $error("programming did not finish");
endmodule

`default_nettype wire

// ### testbench/eep_master_model.sv
// two-wire bus master model: drives the clock, pulls the data line low
`timescale 1ns/10ps
`default_nettype none

module eep_master_model (
    // system
    input  wire logic clk,
    // bus
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // ****************************************
    // timing
    // ****************************************
    // quantum of 12 clk = 48 ns; 10-quantum low and 11-quantum high keep scl under 1 MHz
    localparam int HALF = 11;
    int n_viol = 0;

    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_q(input int n);
        repeat (n * 12) @(negedge clk);
    endtask

    // ****************************************
    // conditions and bits
    // ****************************************
    task automatic start_c();
        sda_pull = 1'b0;
        wait_q(5);
        scl = 1'b1;
        wait_q(6);
        sda_pull = 1'b1;
        wait_q(6);
        scl = 1'b0;
    endtask

    task automatic stop_c();
        wait_q(5);
        sda_pull = 1'b1;
        wait_q(6);
        scl = 1'b1;
        wait_q(6);
        sda_pull = 1'b0;
        wait_q(HALF);
    endtask

    task automatic bit_x(input logic b, input logic glitch, output logic rb);
        wait_q(5);
        sda_pull = ~b;
        if (glitch) begin
            // short scl pulse that must not count as an edge
            wait_q(2);
            scl = 1'b1;
            wait_q(1);
            scl = 1'b0;
            wait_q(2);
        end else begin
            wait_q(5);
        end
        scl = 1'b1;
        wait_q(1);
        rb = sda;
        wait_q(HALF - 2);
        if (sda !== rb) n_viol++;
        wait_q(1);
        scl = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] b, input logic glitch, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], glitch, r);
        bit_x(1'b1, 1'b0, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, 1'b0, r);
            d[i] = r;
        end
        bit_x(~mack, 1'b0, r);
    endtask
endmodule

`default_nettype wire

// ### testbench/eep_slave_tb.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/10ps
`default_nettype none

module eep_slave_tb;
    // ****************************************
    // settings and signals
    // ****************************************
    localparam int         PU   = 50;
    localparam int         PROG = 4000;
    localparam logic [3:0] DEVT = 4'h6; // arbitrary type code
    localparam logic [2:0] CS   = 3'h5;
    logic       clk           = 1'b0;
    logic       sys_rst       = 1'b1;
    logic       supply_ok     = 1'b1;
    logic       write_protect = 1'b0;
    logic       scl;
    logic       sda_pull;
    logic       sda_o_ff;
    logic       sda_oe_ff;
    logic       ready_ff;
    logic       prog_busy_ff;
    logic       ack;
    logic [7:0] rd;
    wire        sda_w = ~(sda_pull | sda_oe_ff);
    int         n_errors  = 0;
    int         tests_run = 0;
    int         k;

    eep_slave #(.PU_CYCLES(PU), .PROG_CYCLES(PROG), .DEV_TYPE(DEVT)) DUT (
        .clk(clk), .sys_rst(sys_rst), .supply_ok(supply_ok),
        .scl_i(scl), .sda_i(sda_w), .sda_o_ff(sda_o_ff), .sda_oe_ff(sda_oe_ff),
        .chip_select_bit0(CS[0]), .chip_select_bit1(CS[1]), .chip_select_bit2(CS[2]),
        .write_protect(write_protect), .ready_ff(ready_ff), .prog_busy_ff(prog_busy_ff)
    );

    eep_master_model master (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda(sda_w));

    initial begin
        forever #2 clk = ~clk;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic send_addr(input logic [2:0] c, input logic rw, input logic g);
        master.start_c();
        master.wr_byte({DEVT, c, rw}, g, ack);
    endtask

    task automatic set_ptr(input logic [11:0] a);
        send_addr(CS, 1'b0, 1'b0);
        check("addr_ack", 8'h01, {7'h0, ack});
        master.wr_byte({4'h0, a[11:8]}, 1'b0, ack);
        check("hi_ack", 8'h01, {7'h0, ack});
        master.wr_byte(a[7:0], 1'b0, ack);
        check("lo_ack", 8'h01, {7'h0, ack});
    endtask

    task automatic wait_ready();
        for (k = 0; k < PU + 10 && ready_ff !== 1'b1; k++) @(negedge clk);
    endtask

    // data line only ever pulled low
    always @(negedge clk) begin
        if (sda_oe_ff === 1'b1) check("sda_o_ff", 8'h00, {7'h0, sda_o_ff});
    end

    initial begin
        repeat (120000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check("ready_rst", 8'h00, {7'h0, ready_ff});
        wait_ready();
        check("ready_ff", 8'h01, {7'h0, ready_ff});
        check("ready_late", 8'h01, {7'h0, k >= PU - 1});
        for (int c = 0; c < 8; c++) begin
            send_addr(3'(c), 1'b0, 1'b0);
            check("cs_match", {7'h0, c == CS}, {7'h0, ack});
        end
        master.start_c();
        master.wr_byte({~DEVT, CS, 1'b0}, 1'b0, ack);
        master.stop_c();
        check("type_nack", 8'h00, {7'h0, ack});
        send_addr(CS, 1'b0, 1'b1);
        check("glitch_ack", 8'h01, {7'h0, ack});
        master.wr_byte(8'h01, 1'b0, ack);
        master.wr_byte(8'h20, 1'b0, ack);
        for (int i = 0; i < 17; i++) begin
            master.wr_byte(8'h50 + 8'(i), 1'b0, ack);
            check("page_ack", {7'h0, i < 16}, {7'h0, ack});
        end
        master.stop_c();
        check("busy", 8'h01, {7'h0, prog_busy_ff});
        send_addr(CS, 1'b0, 1'b0);
        master.stop_c();
        check("busy_nack", 8'h00, {7'h0, ack});
        send_addr(CS, 1'b0, 1'b0);
        master.stop_c();
        check("poll_ack", 8'h01, {7'h0, ack});
        write_protect = 1'b1;
        set_ptr(12'h124);
        master.wr_byte(8'h3c, 1'b0, ack);
        check("wp_nack", 8'h00, {7'h0, ack});
        master.stop_c();
        check("wp_idle", 8'h00, {7'h0, prog_busy_ff});
        write_protect = 1'b0;
        set_ptr(12'h123);
        send_addr(CS, 1'b1, 1'b0);
        check("rd_ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < 2; i++) begin
            master.rd_byte(1'(i == 0), rd);
            check("rd_data", 8'h53 + 8'(i), rd);
        end
        master.stop_c();
        check("out_stable", 8'h00, 8'(master.n_viol));
        supply_ok = 1'b0;
        repeat (8) @(negedge clk);
        check("brownout", 8'h00, {7'h0, ready_ff});
        send_addr(CS, 1'b0, 1'b0);
        master.stop_c();
        check("brown_nack", 8'h00, {7'h0, ack});
        supply_ok = 1'b1;
        wait_ready();
        check("ready_again", 8'h01, {7'h0, ready_ff});
        send_addr(CS, 1'b0, 1'b0);
        master.stop_c();
        check("standby_ack", 8'h01, {7'h0, ack});
        tally_and_finish();
    end
endmodule

`default_nettype wire
